// file: core/dew_debug_enclave_write.sv
// Checker and executor of the debug enclave word write leaf
`timescale 1ns/1ps
`default_nettype none
`include "dew_defines.svh"

module dew_debug_enclave_write #(
    parameter int ADDR_W = 64,
    parameter int VA_BITS = 48,
    parameter int OWNER_W = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Leaf request from the instruction sequencer
    input wire logic enclave_system_op,
    input wire logic [31:0] leaf_select,
    input wire logic [63:0] write_data_register,
    input wire logic [ADDR_W-1:0] target_address_register,
    input wire logic [ADDR_W-1:0] data_segment_base,
    input wire logic long_mode_active_bit,
    input wire logic code_segment_long_bit,
    input wire logic [1:0] privilege_level,
    input wire logic segment_violation,
    input wire logic data_segment_unusable,
    input wire logic page_map_modifier_busy,
    // Page map lookup port
    output logic map_req,
    output logic [ADDR_W-1:0] map_addr,
    input wire logic map_ack,
    input wire logic map_in_cache,
    input wire logic map_valid,
    input wire dew_pkg::dew_page_type_e map_page_type,
    input wire logic map_pending,
    input wire logic map_modified,
    input wire logic [2:0] map_rwx,
    input wire logic [OWNER_W-1:0] owning_structure_pointer,
    input wire logic owner_debug,
    // Enclave memory write port
    output logic mem_wr,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [63:0] mem_wdata,
    output logic [7:0] mem_be,
    input wire logic mem_ack,
    // Completion and architectural results
    output logic done,
    output logic fault_gp,
    output logic fault_pf,
    output logic [ADDR_W-1:0] fault_addr,
    output logic [15:0] gp_error_code,
    output logic result_we,
    output logic [63:0] result_register,
    output logic zero_flag,
    output logic flags_cleared,
    output logic [OWNER_W-1:0] owner_seen
);
    import dew_pkg::*;

    // ----------------------------------------------------------------
    // Operating notes
    // ----------------------------------------------------------------
    // The unit runs one leaf at a time. A request is a single cycle of
    // enclave_system_op with the leaf selector at the debug write code,
    // seen while the sequencer is idle. Anything that arrives while an
    // operation is in flight is dropped without a trace, so the issuing
    // sequencer must wait for the done pulse before the next request.
    // The cycle that carries done is already idle and may carry the next
    // request, so leaves can run back to back.
    //
    // Operands are captured on the request edge. The data word, target
    // address, segment base and mode bits may change freely afterwards.
    // Privilege, segment state and the alignment and canonical checks
    // are all judged on that same edge, so an early protection fault is
    // reported one cycle after the request and the page map is never
    // asked. This keeps faulting leaves short and the map port free.
    //
    // Lookup phase: map_req rises the cycle after the request and holds,
    // with map_addr, until map_ack. Every field of the map answer is used
    // only in the acknowledge cycle, so the responder may change them
    // freely at other times. The concurrent modifier flag is sampled in
    // that same cycle, which is the moment the entry is actually read.
    // Sampling it at the request edge instead would miss a modifier that
    // starts while the lookup is waiting.
    //
    // The lookup checks form one chain of qualified terms. Each term
    // carries the negation of every earlier check, so at most one of
    // them is true in any acknowledge cycle and the first failure alone
    // selects the outcome. Adding a check means extending the chain at
    // its place in the order, not merely adding an or-term at the end.
    //
    // Write phase: mem_wr rises in the cycle after the acknowledge only
    // when every check has passed, and holds with address, data and
    // byte enables until mem_ack. Narrow mode writes the low four byte
    // lanes and drives zero on the upper half of the data bus, so a
    // memory that ignores the enables still cannot take stale bytes.
    // No prefix or override reaches this unit, so the width is decided
    // by the two mode bits alone.
    //
    // Results: done and the fault pulses stand for exactly one cycle.
    // result_register and zero_flag change only on the not-debuggable
    // path and on a successful write; faults leave them untouched, since
    // a faulting leaf has no architectural result of its own. The fault
    // address is the linear address seen by the map, not the raw
    // register, because the segment base is folded in at the request.
    // flags_cleared tells the flag logic outside to clear the carry,
    // parity, adjust, overflow and sign flags on every completion that
    // does not fault.
    //
    // The permission bits of the map entry arrive on map_rwx only so that
    // the port list mirrors the entry format. They are folded into an
    // unused term and never reach a decision: a debugger must be able
    // to patch code and read-only data alike.
    //
    // Limitations: the unit does not translate addresses; the residency
    // answer comes from the map responder. The owner's debug attribute
    // is likewise fetched outside and offered with the acknowledge.
    // The owning structure pointer is kept on owner_seen for the
    // debugger's trace; it does not steer any decision here.
    // A synchronous reset drops an operation in flight without a done
    // pulse, and the issuing side must not wait for one.
    //
    // Reset: every output register returns to zero and the sequencer to
    // idle. A request may be made on the first edge after reset is
    // released; nothing needs time to settle.
    //
    // Timing: the longest path runs from the map answer through the
    // check chain into the outcome registers. It is one level of and-or
    // terms deep, chosen over a faster pipelined check stage.

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    dew_state_e state;
    dew_state_e next_state;
    logic wide;
    logic [ADDR_W-1:0] lin;
    logic [63:0] data;

    // Operation fires only for the debug write leaf
    wire logic start = enclave_system_op &&
        (leaf_select == `DEW_LEAF_DEBUG_WRITE);
    wire logic req_wide = long_mode_active_bit &&
        code_segment_long_bit;
    // Linear address through the data segment, no override possible
    wire logic [ADDR_W-1:0] req_lin = data_segment_base +
        target_address_register;

    // Canonical check: top bits copy the last implemented bit
    function automatic logic is_canonical(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = 1'b1;
        for (int i = VA_BITS; i < ADDR_W; i++) begin
            if (a[i] != a[VA_BITS-1]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // Early checks, in priority order
    wire logic mis_wide = req_wide && (req_lin[2:0] != 3'h0);
    wire logic mis_narrow = !req_wide && (req_lin[1:0] != 2'h0);
    wire logic early_gp = mis_wide || mis_narrow ||
        segment_violation || data_segment_unusable ||
        (privilege_level != 2'h0) ||
        (req_wide && !is_canonical(req_lin));

    // Lookup checks; permission bits are deliberately never examined
    wire logic type_ok = (map_page_type == DEW_PAGE_REG) ||
        (map_page_type == DEW_PAGE_TCS);
    wire logic flags_ok = (map_page_type != DEW_PAGE_TCS) ||
        ((lin[11:0] & `DEW_PAGE_MASK) ==
         (`DEW_FLAGS_OFFSET & `DEW_PAGE_MASK));
    wire logic chk_pf_res = !map_in_cache;
    wire logic chk_gp_busy = map_in_cache && page_map_modifier_busy;
    wire logic chk_pf_val = map_in_cache && !page_map_modifier_busy &&
        !map_valid;
    wire logic pre_type = map_in_cache && !page_map_modifier_busy &&
        map_valid;
    wire logic chk_pf_type = pre_type && !type_ok;
    wire logic chk_pend = pre_type && type_ok &&
        (map_pending || map_modified);
    wire logic pre_flags = pre_type && type_ok && !map_pending &&
        !map_modified;
    wire logic chk_gp_flags = pre_flags && !flags_ok;
    wire logic chk_gp_dbg = pre_flags && flags_ok && !owner_debug;
    wire logic all_ok = pre_flags && flags_ok && owner_debug;
    wire logic lookup_pf = chk_pf_res || chk_pf_val || chk_pf_type;
    wire logic lookup_gp = chk_gp_busy || chk_gp_flags || chk_gp_dbg;
    wire logic unused_rwx = ^map_rwx;

    // Byte enables and data lane follow the mode, never a prefix
    wire logic [7:0] be_sel = wide ? 8'hFF : 8'h0F;
    wire logic [63:0] data_sel = wide ? data :
        {32'h0000_0000, data[31:0]};

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            DEW_IDLE: begin
                if (start && !early_gp) begin
                    next_state = DEW_LOOKUP;
                end
            end
            DEW_LOOKUP: begin
                if (map_ack && all_ok) begin
                    next_state = DEW_WRITE;
                end else if (map_ack) begin
                    next_state = DEW_IDLE;
                end
            end
            DEW_WRITE: begin
                if (mem_ack) begin
                    next_state = DEW_IDLE;
                end
            end
            default: begin
                next_state = DEW_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= DEW_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Captured operands; held stable for the whole operation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wide <= 1'b0;
            lin <= '0;
            data <= 64'h0000_0000_0000_0000;
        end else if (state == DEW_IDLE && start) begin
            wide <= req_wide;
            lin <= req_lin;
            data <= write_data_register;
        end
    end

    // Lookup request stays up until the map answers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            map_req <= 1'b0;
            map_addr <= '0;
        end else if (state == DEW_IDLE && start && !early_gp) begin
            map_req <= 1'b1;
            map_addr <= req_lin;
        end else if (state == DEW_LOOKUP && map_ack) begin
            map_req <= 1'b0;
        end
    end

    // Memory write only after every check has passed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_wr <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= 64'h0000_0000_0000_0000;
            mem_be <= 8'h00;
        end else if (state == DEW_LOOKUP && map_ack && all_ok) begin
            mem_wr <= 1'b1;
            mem_addr <= lin;
            mem_wdata <= data_sel;
            mem_be <= be_sel;
        end else if (state == DEW_WRITE && mem_ack) begin
            mem_wr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Outcome reporting
    // ----------------------------------------------------------------
    wire logic do_early = (state == DEW_IDLE) && start && early_gp;
    wire logic do_look = (state == DEW_LOOKUP) && map_ack;
    wire logic do_pend = do_look && chk_pend;
    wire logic do_ok = (state == DEW_WRITE) && mem_ack;

    // One-cycle outcome pulses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done <= 1'b0;
            fault_gp <= 1'b0;
            fault_pf <= 1'b0;
            result_we <= 1'b0;
            flags_cleared <= 1'b0;
        end else begin
            done <= do_early || do_look && !all_ok || do_ok;
            fault_gp <= do_early || do_look && lookup_gp;
            fault_pf <= do_look && lookup_pf;
            result_we <= do_pend || do_ok;
            flags_cleared <= do_pend || do_ok;
        end
    end

    // Fault address and result values, held until the next outcome
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_addr <= '0;
            gp_error_code <= 16'h0000;
            result_register <= 64'h0000_0000_0000_0000;
            zero_flag <= 1'b0;
            owner_seen <= '0;
        end else begin
            if (do_look && lookup_pf) begin
                fault_addr <= lin;
            end
            if (do_early || do_look && lookup_gp) begin
                gp_error_code <= 16'h0000;
            end
            if (do_look) begin
                owner_seen <= owning_structure_pointer;
            end
            if (do_pend) begin
                result_register <= `DEW_NOT_DEBUGGABLE_CODE;
                zero_flag <= 1'b1;
            end else if (do_ok) begin
                result_register <= 64'h0000_0000_0000_0000;
                zero_flag <= 1'b0;
            end
        end
    end
endmodule // dew_debug_enclave_write
`default_nettype wire

// file: core/dew_defines.svh
// Constants for the debug enclave word write unit
`ifndef DEW_DEFINES_SVH
`define DEW_DEFINES_SVH
`define DEW_LEAF_DEBUG_WRITE 32'h0000_0005
`define DEW_PAGE_MASK 12'hFF8
`define DEW_FLAGS_OFFSET 12'h008
`define DEW_NOT_DEBUGGABLE_CODE 64'h0000_0000_0000_0019
`define DEW_LINE_RESP_MAX 16'h0100
`endif

// file: core/dew_pkg.sv
// Types for the debug enclave word write unit
package dew_pkg;
    typedef enum logic [1:0] {
        DEW_OUT_NONE,
        DEW_OUT_DONE,
        DEW_OUT_GP,
        DEW_OUT_PF
    } dew_outcome_e;
    typedef enum logic [2:0] {
        DEW_PAGE_ENCLAVE_CONTROL_STRUCTURE,
        DEW_PAGE_TCS,
        DEW_PAGE_REG,
        DEW_PAGE_VA,
        DEW_PAGE_TRIM,
        DEW_PAGE_OTHER
    } dew_page_type_e;
    typedef enum logic [1:0] {
        DEW_IDLE,
        DEW_LOOKUP,
        DEW_WRITE,
        DEW_FINISH
    } dew_state_e;
endpackage

// file: tb/dew_chk_sva.sv
// Assertion checker for the debug enclave word write unit
`timescale 1ns/1ps
`default_nettype none
module dew_chk_sva #(
    parameter int ADDR_W = 64
) (
    // Clock, reset and request
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enclave_system_op,
    input wire logic [31:0] leaf_select,
    input wire logic [ADDR_W-1:0] target_address_register,
    input wire logic long_mode_active_bit,
    input wire logic code_segment_long_bit,
    input wire logic [1:0] privilege_level,
    input wire logic page_map_modifier_busy,
    // Lookup and write ports
    input wire logic map_ack,
    input wire logic map_in_cache,
    input wire logic map_valid,
    input wire logic mem_wr,
    input wire logic [7:0] mem_be,
    input wire logic mem_ack,
    // Results
    input wire logic done,
    input wire logic fault_gp,
    input wire logic fault_pf,
    input wire logic [15:0] gp_error_code,
    input wire logic [63:0] result_register,
    input wire logic zero_flag,
    input wire logic flags_cleared
);
    logic busy;
    logic wide;
    // The done cycle is already idle, so a request there is taken too
    wire take = enclave_system_op && leaf_select == 32'h0000_0005 &&
        (!busy || done);
    wire [ADDR_W-1:0] ta = target_address_register;
    // Own copy of the in-flight state, since requests while busy are ignored
    always_ff @(posedge clk) begin
        if (sys_rst) busy <= 1'b0;
        else if (take) busy <= 1'b1;
        else if (done) busy <= 1'b0;
    end
    // Mode is fixed at the request edge
    always_ff @(posedge clk) begin
        if (take) wide <= long_mode_active_bit && code_segment_long_bit;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_priv_fault: assert property (take && privilege_level != 2'h0
        |=> done && fault_gp) else $error("privilege fault missing");
    chk_wide_align: assert property (take && long_mode_active_bit
        && code_segment_long_bit && ta[2:0] != 3'h0 |=> done && fault_gp)
        else $error("wide misalignment not faulted");
    chk_narrow_align: assert property (take && ta[1:0] != 2'h0
        && !(long_mode_active_bit && code_segment_long_bit)
        |=> done && fault_gp) else $error("narrow misalignment not faulted");
    chk_gp_zero: assert property (fault_gp
        |-> gp_error_code == 16'h0000)
        else $error("protection fault code not zero");
    chk_write_width: assert property (mem_wr
        |-> mem_be == (wide ? 8'hFF : 8'h0F))
        else $error("write width wrong");
    chk_cache_miss: assert property (map_ack && !map_in_cache
        |=> done && fault_pf && !mem_wr) else $error("page cache miss wrong");
    chk_invalid_pf: assert property (map_ack && map_in_cache
        && !page_map_modifier_busy && !map_valid |=> fault_pf)
        else $error("invalid entry not page faulted");
    chk_success_clear: assert property (mem_wr && mem_ack
        |=> done && flags_cleared && result_register == 64'h0 && !zero_flag)
        else $error("success results wrong");
    cover property (mem_wr && mem_ack);
    cover property (done && fault_pf);
    cover property (done && zero_flag);
endmodule // dew_chk_sva
bind dew_debug_enclave_write dew_chk_sva #(.ADDR_W(ADDR_W)) i_chk (
    .clk, .sys_rst, .enclave_system_op, .leaf_select, .target_address_register,
    .long_mode_active_bit, .code_segment_long_bit, .privilege_level,
    .page_map_modifier_busy, .map_ack, .map_in_cache, .map_valid, .mem_wr,
    .mem_be, .mem_ack, .done, .fault_gp, .fault_pf, .gp_error_code,
    .result_register, .zero_flag, .flags_cleared);
`default_nettype wire

// file: tb/dew_map_model.sv
// Page map and enclave memory responder for the bench
`timescale 1ns/1ps
`default_nettype none
module dew_map_model (
    // Clock and bench configuration
    input wire logic clk,
    input wire logic [3:0] dly,
    input wire logic [4:0] cfg,
    // Lookup and write ports
    input wire logic map_req,
    output logic map_ack,
    output logic map_in_cache,
    output logic map_valid,
    output logic map_pending,
    output logic map_modified,
    output logic owner_debug,
    input wire logic mem_wr,
    output logic mem_ack,
    output int writes
);
    logic [3:0] cnt = 4'h0;
    initial map_ack = 1'b0;
    initial mem_ack = 1'b0;
    initial writes = 0;
    // Fields are inverted outside the ack cycle so stale values never match
    assign {map_in_cache, map_valid, map_pending, map_modified, owner_debug} =
        map_ack ? cfg : ~cfg;
    // Lookup answers dly+1 cycles after map_req rises; writes answer next cycle
    always @(posedge clk) begin
        map_ack <= map_req && !map_ack && cnt == dly;
        cnt <= (map_req && !map_ack) ? cnt + 4'h1 : 4'h0;
        mem_ack <= mem_wr && !mem_ack;
        if (mem_wr && !mem_ack) writes <= writes + 1;
    end
endmodule // dew_map_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the debug enclave word write unit
`timescale 1ns/1ps
`default_nettype none
`include "dew_defines.svh"
module tb;
    import dew_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, op = 1'b0, lm = 1'b0, csl = 1'b0;
    logic segv = 1'b0, unus = 1'b0, mbusy = 1'b0;
    logic [1:0] priv = 2'h0;
    logic [2:0] rwx = 3'h0;
    logic [3:0] dly = 4'h0;
    logic [4:0] cfg = 5'h00;
    logic [31:0] leaf = 32'h0000_0000;
    logic [63:0] wd = 64'hA5C3_0123_4567_89AB, ta = 64'h0;
    logic [63:0] w_addr, w_data;
    logic [7:0] w_be;
    dew_page_type_e pt = DEW_PAGE_REG;
    logic map_req, map_ack, map_in_cache, map_valid, map_pending, map_modified;
    logic owner_debug, mem_wr, mem_ack, done, fault_gp, fault_pf, result_we;
    logic zero_flag, flags_cleared;
    logic [63:0] mem_addr, mem_wdata, fault_addr, result_register, owner_seen;
    logic [7:0] mem_be;
    logic [15:0] gp_error_code;
    int writes, miscompares = 0, comparisons = 0, cycles = 0;
    always #2.5 clk = ~clk;
    dew_debug_enclave_write i_dut (.clk, .sys_rst, .enclave_system_op(op),
        .leaf_select(leaf), .write_data_register(wd),
        .target_address_register(ta), .data_segment_base(64'h0),
        .long_mode_active_bit(lm), .code_segment_long_bit(csl),
        .privilege_level(priv), .segment_violation(segv),
        .data_segment_unusable(unus), .page_map_modifier_busy(mbusy),
        .map_req, .map_addr(), .map_ack, .map_in_cache, .map_valid,
        .map_page_type(pt), .map_pending, .map_modified, .map_rwx(rwx),
        .owning_structure_pointer(64'h0000_0000_0004_0000), .owner_debug,
        .mem_wr, .mem_addr, .mem_wdata, .mem_be, .mem_ack, .done, .fault_gp,
        .fault_pf, .fault_addr, .gp_error_code, .result_we, .result_register,
        .zero_flag, .flags_cleared, .owner_seen);
    dew_map_model i_map (.clk, .dly, .cfg, .map_req, .map_ack, .map_in_cache,
        .map_valid, .map_pending, .map_modified, .owner_debug, .mem_wr,
        .mem_ack, .writes);
    // Keep the last word written, taken as the write is acknowledged
    always @(posedge clk) begin
        if (mem_wr && mem_ack) begin
            {w_addr, w_data, w_be} <= {mem_addr, mem_wdata, mem_be};
        end
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            end_of_test;
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
            input string name);
        comparisons++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask
    // One leaf: m = {long, code long, cpl, seg fault, unusable, map busy}
    // e = 0 write, 1 not debuggable, 2 protection fault, 3 page fault
    task automatic run(input logic [5:0] m, input logic [63:0] a,
            input dew_page_type_e t, input logic [4:0] c, input logic [1:0] e);
        int n;
        int w0;
        logic [63:0] xd;
        {lm, csl, priv[0], segv, unus, mbusy} = m;
        {ta, pt, cfg} = {a, t, c};
        dly = dly + 4'h3;
        rwx = rwx + 3'h1;
        wd = {wd[31:0], wd[63:32]} ^ a;
        xd = (m[5] & m[4]) ? wd : {32'h0, wd[31:0]};
        w0 = writes;
        op = 1'b1;
        leaf = 32'h0000_0005;
        @(negedge clk);
        op = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk(done, 1'b1, "done");
        chk(fault_gp, e == 2'h2, "fault_gp");
        chk(fault_pf, e == 2'h3, "fault_pf");
        chk(writes, w0 + (e == 2'h0), "writes");
        if (e == 2'h3) chk(fault_addr, a, "fault_addr");
        if (e == 2'h2) chk(gp_error_code, 64'h0, "gp_error_code");
        chk(result_we, e < 2'h2, "result_we");
        if (e < 2'h2) begin
            chk(result_register, e[0] ? `DEW_NOT_DEBUGGABLE_CODE : 64'h0,
                "result");
            chk(zero_flag, e[0], "zero_flag");
            chk(flags_cleared, 1'b1, "flags_cleared");
            chk(owner_seen, 64'h0000_0000_0004_0000, "owner_seen");
        end
        if (e == 2'h0) begin
            chk(w_addr, a, "mem_addr");
            chk(w_data, xd, "mem_wdata");
            chk(w_be, (m[5] & m[4]) ? 8'hFF : 8'h0F, "mem_be");
        end
        $display("test end address %h", a);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Back-to-back leaves, each requested in the done cycle of the previous one
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        run(6'h30, 64'h0000_7FFF_0000_1238, DEW_PAGE_REG, 5'h19, 2'h0);
        run(6'h20, 64'h0000_7FFF_0000_1234, DEW_PAGE_REG, 5'h19, 2'h0);
        run(6'h30, 64'h0000_7FFF_0000_1234, DEW_PAGE_REG, 5'h19, 2'h2);
        run(6'h00, 64'h0000_0000_0000_1236, DEW_PAGE_REG, 5'h19, 2'h2);
        run(6'h38, 64'h0000_0000_0000_1238, DEW_PAGE_REG, 5'h19, 2'h2);
        run(6'h34, 64'h0000_0000_0000_1238, DEW_PAGE_REG, 5'h19, 2'h2);
        run(6'h32, 64'h0000_0000_0000_1238, DEW_PAGE_REG, 5'h19, 2'h2);
        run(6'h30, 64'h0001_0000_0000_1000, DEW_PAGE_REG, 5'h19, 2'h2);
        run(6'h30, 64'h0000_0000_0000_2000, DEW_PAGE_REG, 5'h09, 2'h3);
        run(6'h31, 64'h0000_0000_0000_2000, DEW_PAGE_REG, 5'h19, 2'h2);
        run(6'h30, 64'h0000_0000_0000_2000, DEW_PAGE_REG, 5'h15, 2'h3);
        run(6'h30, 64'h0000_0000_0000_3000, DEW_PAGE_ENCLAVE_CONTROL_STRUCTURE, 5'h19, 2'h3);
        run(6'h30, 64'h0000_0000_0000_3000, DEW_PAGE_VA, 5'h19, 2'h3);
        run(6'h30, 64'h0000_0000_0000_3000, DEW_PAGE_TRIM, 5'h19, 2'h3);
        run(6'h30, 64'h0000_0000_0000_4000, DEW_PAGE_REG, 5'h1D, 2'h1);
        run(6'h00, 64'h0000_0000_0000_4004, DEW_PAGE_TCS, 5'h1A, 2'h1);
        run(6'h30, 64'h0000_0000_0000_5010, DEW_PAGE_TCS, 5'h19, 2'h2);
        run(6'h30, 64'h0000_0000_0000_5008, DEW_PAGE_TCS, 5'h19, 2'h0);
        run(6'h30, 64'h0000_0000_0000_6000, DEW_PAGE_REG, 5'h18, 2'h2);
        op = 1'b1;
        leaf = 32'h0000_0006;
        @(negedge clk);
        op = 1'b0;
        repeat (8) begin
            @(negedge clk);
            chk(done, 1'b0, "done");
        end
        end_of_test;
    end
endmodule // tb
`default_nettype wire
